// ===== logic/fdcrp_regs.sv
// Purpose: rate/precompensation control register and command/result data port
// Assumes: host bus strobes are one-cycle and synchronous to i_clk
// Notes:   results leave in the order they were produced, first status byte first
`timescale 1ns/1ps
`include "fdcrp_params.svh"

module fdcrp_regs #(
  parameter int DEPTH = `FDCRP_STACK_DEPTH
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  // host register bus
  input  wire fdcrp_pkg::fdcrp_bus_t i_bus,
  output logic [7:0]                o_rdata,
  // rate-control register and configuration
  input  wire logic                 i_rcr_wr,
  input  wire logic [1:0]           i_rcr_rate,
  input  wire logic                 i_compat_mode,
  input  wire logic [1:0]           i_tape_rate_cfg,
  // command sequencer
  input  wire logic                 i_configure,
  input  wire logic                 i_cfg_fifo_on,
  input  wire logic                 i_end_evt,
  input  wire fdcrp_pkg::fdcrp_end_t i_end_info,
  input  wire logic                 i_res_push,
  input  wire logic [7:0]           i_res_byte,
  output logic                      o_cmd_valid,
  output logic [7:0]                o_cmd_byte,
  // controller and drive control
  output logic                      o_soft_reset,
  output logic                      o_power_down,
  output logic                      o_fifo_enable,
  output logic [1:0]                o_rate_code,
  output logic                      o_tape_2m,
  output logic                      o_reduced_write_current_n,
  output logic [3:0]                o_precomp_units,
  // handshake status
  output logic                      o_host_transfer_request,
  output logic                      o_transfer_direction
);

  // delay in 20.83 ns units; tape steps are half the disk steps
  function automatic logic [3:0] precomp_units(input logic [2:0] code,
                                               input logic [1:0] rate,
                                               input logic       tape);
    logic [3:0] u;
    u = 4'h0;
    if (code == `FDCRP_PC_DEFAULT) begin
      if (tape)
        u = `FDCRP_DLY_DEF_2M;
      else if (rate == `FDCRP_RATE_1M)
        u = `FDCRP_DLY_DEF_1M;
      else
        u = `FDCRP_DLY_DEF_SLOW;
    end else if (code == `FDCRP_PC_OFF) begin
      u = 4'h0;
    end else if (tape) begin
      u = {1'b0, code};
    end else begin
      u = {code, 1'b0};
    end
    return u;
  endfunction

  fdcrp_pkg::fdcrp_state_t state_r, state_nxt;
  logic [7:0] mem_r [DEPTH];
  logic [7:0] mem_nxt [DEPTH];
  logic [1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] rate_reg_r, rate_reg_nxt;
  logic       src_rcr_r, src_rcr_nxt;
  logic [1:0] rcr_rate_r, rcr_rate_nxt;
  logic [7:0] rdata_nxt;
  logic       cmd_valid_nxt, swrst_nxt, fifo_en_nxt;
  logic [7:0] cmd_byte_nxt;
  logic [1:0] rate_nxt;
  logic       tape_nxt, req_nxt, dir_nxt, rwc_nxt;
  logic [3:0] pc_nxt;
  logic       wr_rate, wr_port, rd_port, rd_stat, pop, push_status0;
  logic [7:0] status0;
  logic [2:0] cnt_tmp;

  assign wr_rate = i_bus.wr && (i_bus.addr == `FDCRP_OFS_RATE);
  assign wr_port = i_bus.wr && (i_bus.addr == `FDCRP_OFS_PORT);
  assign rd_port = i_bus.rd && (i_bus.addr == `FDCRP_OFS_PORT);
  assign rd_stat = i_bus.rd && (i_bus.addr == `FDCRP_OFS_RATE);

  // first result status byte
  assign status0 = {i_end_info.term,
                    i_end_info.seek_ok,
                    i_end_info.fault ||
                    (!i_end_info.trk0_seen &&
                     i_end_info.steps >= `FDCRP_RECAL_STEPS),
                    i_end_info.unready,
                    i_end_info.head,
                    i_end_info.unit};

  // reads only drain while results are pending in the read direction
  assign pop          = rd_port && (state_r == fdcrp_pkg::FDCRP_RES)
                        && (cnt_r != 3'h0);
  assign push_status0 = i_end_evt && (state_r == fdcrp_pkg::FDCRP_CMD);

  always_comb begin
    state_nxt     = state_r;
    mem_nxt       = mem_r;
    wp_nxt        = wp_r;
    rp_nxt        = rp_r;
    cnt_tmp       = cnt_r;
    rate_reg_nxt  = rate_reg_r;
    src_rcr_nxt   = src_rcr_r;
    rcr_rate_nxt  = rcr_rate_r;
    cmd_valid_nxt = 1'b0;
    cmd_byte_nxt  = o_cmd_byte;
    swrst_nxt     = 1'b0;
    fifo_en_nxt   = o_fifo_enable;
    rdata_nxt     = o_rdata;

    if (i_rcr_wr) begin
      rcr_rate_nxt = i_rcr_rate;
      src_rcr_nxt  = 1'b1;
    end
    if (wr_rate) begin
      rate_reg_nxt = {1'b0, i_bus.wdata[`FDCRP_BIT_PDOWN], 1'b0,
                      i_bus.wdata[4:0]};
      src_rcr_nxt  = 1'b0;
      swrst_nxt  = i_bus.wdata[`FDCRP_BIT_SWRST];
    end
    if (i_configure)
      fifo_en_nxt = i_cfg_fifo_on;

    // commands and parameters go straight to the sequencer
    if (wr_port && state_r == fdcrp_pkg::FDCRP_CMD) begin
      cmd_valid_nxt = 1'b1;
      cmd_byte_nxt  = i_bus.wdata;
    end

    if (pop) begin
      rdata_nxt = mem_r[rp_r];
      rp_nxt    = rp_r + 2'h1;
      cnt_tmp   = cnt_tmp - 3'h1;
    end else if (rd_stat) begin
      rdata_nxt = {o_host_transfer_request, o_transfer_direction, 6'h00};
    end else if (i_bus.rd) begin
      rdata_nxt = 8'h00;
    end

    // overflow beyond four bytes is dropped without notice to the sequencer
    if ((push_status0 || (i_res_push && state_r == fdcrp_pkg::FDCRP_RES))
        && cnt_tmp < DEPTH[2:0]) begin
      mem_nxt[wp_r] = push_status0 ? status0 : i_res_byte;
      wp_nxt        = wp_r + 2'h1;
      cnt_tmp       = cnt_tmp + 3'h1;
    end

    case (state_r)
      fdcrp_pkg::FDCRP_CMD: begin
        if (push_status0)
          state_nxt = fdcrp_pkg::FDCRP_RES;
      end
      fdcrp_pkg::FDCRP_RES: begin
        if (cnt_tmp == 3'h0)
          state_nxt = fdcrp_pkg::FDCRP_CMD;
      end
      default: state_nxt = fdcrp_pkg::FDCRP_CMD;
    endcase

    // software reset flushes results and turns buffering back off
    if (swrst_nxt) begin
      state_nxt   = fdcrp_pkg::FDCRP_CMD;
      wp_nxt      = 2'h0;
      rp_nxt      = 2'h0;
      cnt_tmp     = 3'h0;
      fifo_en_nxt = 1'b0;
    end
    cnt_nxt = cnt_tmp;

    if (i_compat_mode || src_rcr_nxt)
      rate_nxt = rcr_rate_nxt;
    else
      rate_nxt = rate_reg_nxt[1:0];
    tape_nxt = (rate_nxt == `FDCRP_RATE_300K) &&
               (i_tape_rate_cfg == `FDCRP_TAPE_2M_CFG);
    rwc_nxt  = (rate_nxt == `FDCRP_RATE_500K) ||
               (rate_nxt == `FDCRP_RATE_1M);
    pc_nxt   = precomp_units(rate_reg_nxt[4:2], rate_nxt, tape_nxt);
    dir_nxt  = (state_nxt == fdcrp_pkg::FDCRP_RES);
    req_nxt  = dir_nxt ? (cnt_nxt != 3'h0) : !rate_reg_nxt[`FDCRP_BIT_PDOWN];
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_r                   <= fdcrp_pkg::FDCRP_CMD;
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= 8'h00;
      wp_r                      <= 2'h0;
      rp_r                      <= 2'h0;
      cnt_r                     <= 3'h0;
      rate_reg_r                <= `FDCRP_RATE_RESET;
      src_rcr_r                 <= 1'b0;
      rcr_rate_r                <= `FDCRP_RATE_250K;
      o_rdata                   <= 8'h00;
      o_cmd_valid               <= 1'b0;
      o_cmd_byte                <= 8'h00;
      o_soft_reset              <= 1'b0;
      o_power_down              <= 1'b0;
      o_fifo_enable             <= 1'b0;
      o_rate_code               <= `FDCRP_RATE_250K;
      o_tape_2m                 <= 1'b0;
      o_reduced_write_current_n <= 1'b0;
      o_precomp_units           <= `FDCRP_DLY_DEF_SLOW;
      o_host_transfer_request   <= 1'b1;
      o_transfer_direction      <= 1'b0;
    end else begin
      state_r                   <= state_nxt;
      mem_r                     <= mem_nxt;
      wp_r                      <= wp_nxt;
      rp_r                      <= rp_nxt;
      cnt_r                     <= cnt_nxt;
      rate_reg_r                <= rate_reg_nxt;
      src_rcr_r                 <= src_rcr_nxt;
      rcr_rate_r                <= rcr_rate_nxt;
      o_rdata                   <= rdata_nxt;
      o_cmd_valid               <= cmd_valid_nxt;
      o_cmd_byte                <= cmd_byte_nxt;
      o_soft_reset              <= swrst_nxt;
      o_power_down              <= rate_reg_nxt[`FDCRP_BIT_PDOWN];
      o_fifo_enable             <= fifo_en_nxt;
      o_rate_code               <= rate_nxt;
      o_tape_2m                 <= tape_nxt;
      o_reduced_write_current_n <= rwc_nxt;
      o_precomp_units           <= pc_nxt;
      o_host_transfer_request   <= req_nxt;
      o_transfer_direction      <= dir_nxt;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_swrst;
    wr_rate && i_bus.wdata[7] |=> o_soft_reset && !o_fifo_enable
      && !o_transfer_direction;
  endproperty
  a_swrst: assert property (p_swrst) else $error("software reset missing");

  property p_pdown;
    wr_rate |=> o_power_down == $past(i_bus.wdata[6]);
  endproperty
  a_pdown: assert property (p_pdown) else $error("power state wrong");

  property p_rwc;
    o_reduced_write_current_n == (o_rate_code == 2'h0 || o_rate_code == 2'h3);
  endproperty
  a_rwc: assert property (p_rwc) else $error("write current wrong");

  property p_tape;
    o_tape_2m |-> o_rate_code == 2'h1;
  endproperty
  a_tape: assert property (p_tape) else $error("tape rate with bad code");

  property p_pcoff;
    wr_rate && i_bus.wdata[4:2] == 3'h7 |=> o_precomp_units == 4'h0;
  endproperty
  a_pcoff: assert property (p_pcoff) else $error("precomp not disabled");

  property p_cfg;
    $rose(o_fifo_enable) |-> $past(i_configure);
  endproperty
  a_cfg: assert property (p_cfg) else $error("buffering enabled without configure");

  property p_compat;
    i_compat_mode && !i_rcr_wr |=> o_rate_code == $past(rcr_rate_r);
  endproperty
  a_compat: assert property (p_compat) else $error("compat rate not from control");

  property p_status0;
    (push_status0 && !wr_rate && !i_res_push) ##1 (rd_port && !wr_rate)
      |=> o_rdata == $past(status0, 2);
  endproperty
  a_status0: assert property (p_status0) else $error("first status byte wrong");

  property p_dir;
    push_status0 && !(wr_rate && i_bus.wdata[7]) |=> o_transfer_direction
      && o_host_transfer_request;
  endproperty
  a_dir: assert property (p_dir) else $error("result phase not flagged");

endmodule

// ===== logic/fdcrp_params.svh
// Purpose: offsets, fields, reset values and counts for the rate and data port block
// Assumes: byte-wide host register access
// Notes:   delays are counted in units of one sixth of 125 ns (about 20.83 ns)
`ifndef FDCRP_PARAMS_SVH
`define FDCRP_PARAMS_SVH
`define FDCRP_OFS_RATE      3'h4
`define FDCRP_OFS_PORT      3'h5
`define FDCRP_BIT_SWRST     7
`define FDCRP_BIT_PDOWN     6
`define FDCRP_RATE_RESET    8'h02
`define FDCRP_RATE_500K     2'h0
`define FDCRP_RATE_300K     2'h1
`define FDCRP_RATE_250K     2'h2
`define FDCRP_RATE_1M       2'h3
`define FDCRP_TAPE_2M_CFG   2'h2
`define FDCRP_PC_DEFAULT    3'h0
`define FDCRP_PC_OFF        3'h7
`define FDCRP_DLY_DEF_SLOW  4'h6
`define FDCRP_DLY_DEF_1M    4'h2
`define FDCRP_DLY_DEF_2M    4'h1
`define FDCRP_RECAL_STEPS   7'h4d
`define FDCRP_STACK_DEPTH   4
`endif

// ===== logic/fdcrp_pkg.sv
// Purpose: shared types of the rate and data port block
// Assumes: constants come from fdcrp_params.svh
// Notes:   none
package fdcrp_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } fdcrp_bus_t;

  typedef struct packed {
    logic [1:0] term;
    logic       seek_ok;
    logic       fault;
    logic       trk0_seen;
    logic [6:0] steps;
    logic       unready;
    logic       head;
    logic [1:0] unit;
  } fdcrp_end_t;

  typedef enum logic [1:0] {
    FDCRP_CMD = 2'b01,
    FDCRP_RES = 2'b10
  } fdcrp_state_t;
endpackage

// ===== verification/fdcrp_seq_model.sv
// Purpose: command sequencer and rate-control source facing the register block
// Assumes: every request except set_mode is one cycle long, launched 1 ns after a rising edge
// Notes:   data is inverted once its qualifier is released so stale values never look valid
`timescale 1ns/1ps
module fdcrp_seq_model (
  // clock
  input  wire logic             i_clk,
  // towards the block
  output logic                  o_rcr_wr,
  output logic [1:0]            o_rcr_rate,
  output logic                  o_compat_mode,
  output logic [1:0]            o_tape_rate_cfg,
  output logic                  o_configure,
  output logic                  o_cfg_fifo_on,
  output logic                  o_end_evt,
  output fdcrp_pkg::fdcrp_end_t o_end_info,
  output logic                  o_res_push,
  output logic [7:0]            o_res_byte
);
  initial begin
    {o_rcr_wr, o_rcr_rate, o_compat_mode, o_tape_rate_cfg, o_configure} = '0;
    {o_cfg_fifo_on, o_end_evt, o_end_info, o_res_push, o_res_byte} = '0;
  end
  task automatic rcr_write(input logic [1:0] rate);
    @(posedge i_clk) #1;
    o_rcr_wr = 1'b1;
    o_rcr_rate = rate;
    @(posedge i_clk) #1;
    o_rcr_wr = 1'b0;
    o_rcr_rate = ~rate;
  endtask
  task automatic set_mode(input logic compat, input logic [1:0] tape);
    @(posedge i_clk) #1;
    o_compat_mode = compat;
    o_tape_rate_cfg = tape;
  endtask
  task automatic configure(input logic on);
    @(posedge i_clk) #1;
    o_configure = 1'b1;
    o_cfg_fifo_on = on;
    @(posedge i_clk) #1;
    o_configure = 1'b0;
    o_cfg_fifo_on = ~on;
  endtask
  task automatic end_cmd(input fdcrp_pkg::fdcrp_end_t info);
    @(posedge i_clk) #1;
    o_end_evt = 1'b1;
    o_end_info = info;
    @(posedge i_clk) #1;
    o_end_evt = 1'b0;
    o_end_info = ~info;
  endtask
  task automatic push(input logic [7:0] b);
    @(posedge i_clk) #1;
    o_res_push = 1'b1;
    o_res_byte = b;
    @(posedge i_clk) #1;
    o_res_push = 1'b0;
    o_res_byte = ~b;
  endtask
endmodule

// ===== verification/tb_fdc_rate_precomp_fifo_status.sv
// Purpose: self-checking bench of the rate register and command/result port
// Assumes: inputs change 1 ns after a rising edge; answers land one edge later
// Notes:   expected status bytes are rebuilt from the end-of-command fields
`timescale 1ns/1ps
module tb_fdc_rate_precomp_fifo_status;
  logic                  i_clk;
  logic                  i_resetn;
  fdcrp_pkg::fdcrp_bus_t bus;
  logic [7:0]            rdata, cmd_byte, res_byte, d, exp_byte;
  logic [3:0]            pc_units;
  logic [1:0]            rate_code, rcr_rate, tape_cfg;
  logic                  cmd_valid, soft_reset, power_down, fifo_en, tape_2m, rwc_n, req, dir;
  logic                  rcr_wr, compat, cfg, cfg_on, end_evt, res_push;
  fdcrp_pkg::fdcrp_end_t end_info;
  fdcrp_pkg::fdcrp_end_t tbl [4];
  int                    n_mismatch = 0;
  int                    comparisons = 0;

  fdcrp_seq_model seq_u (.i_clk(i_clk), .o_rcr_wr(rcr_wr), .o_rcr_rate(rcr_rate),
    .o_compat_mode(compat), .o_tape_rate_cfg(tape_cfg), .o_configure(cfg),
    .o_cfg_fifo_on(cfg_on), .o_end_evt(end_evt), .o_end_info(end_info),
    .o_res_push(res_push), .o_res_byte(res_byte));
  fdcrp_regs dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_bus(bus), .o_rdata(rdata),
    .i_rcr_wr(rcr_wr), .i_rcr_rate(rcr_rate), .i_compat_mode(compat),
    .i_tape_rate_cfg(tape_cfg), .i_configure(cfg), .i_cfg_fifo_on(cfg_on),
    .i_end_evt(end_evt), .i_end_info(end_info), .i_res_push(res_push),
    .i_res_byte(res_byte), .o_cmd_valid(cmd_valid), .o_cmd_byte(cmd_byte),
    .o_soft_reset(soft_reset), .o_power_down(power_down), .o_fifo_enable(fifo_en),
    .o_rate_code(rate_code), .o_tape_2m(tape_2m), .o_reduced_write_current_n(rwc_n),
    .o_precomp_units(pc_units), .o_host_transfer_request(req),
    .o_transfer_direction(dir));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk) #1;
    bus = {1'b1, 1'b0, a, v};
    @(posedge i_clk) #1;
    bus = {1'b0, 1'b0, ~a, ~v};
  endtask
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clk) #1;
    bus = {1'b0, 1'b1, a, 8'h00};
    @(posedge i_clk) #1;
    bus = {1'b0, 1'b0, ~a, 8'hff};
    v = rdata;
  endtask
  // equipment check also covers a missing track zero after the full step count
  function automatic logic [7:0] status0(input fdcrp_pkg::fdcrp_end_t e);
    return {e.term, e.seek_ok, e.fault | (~e.trk0_seen & (e.steps >= 7'h4d)),
            e.unready, e.head, e.unit};
  endfunction

  initial begin
    repeat (5000) @(posedge i_clk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    i_resetn = 1'b0;
    bus = '0;
    tbl[0] = {2'h0, 1'b1, 1'b0, 1'b0, 7'h4c, 1'b0, 1'b0, 2'h0};
    tbl[1] = {2'h1, 1'b0, 1'b0, 1'b0, 7'h4d, 1'b1, 1'b1, 2'h1};
    tbl[2] = {2'h2, 1'b1, 1'b1, 1'b1, 7'h00, 1'b0, 1'b0, 2'h2};
    tbl[3] = {2'h3, 1'b0, 1'b0, 1'b1, 7'h64, 1'b0, 1'b1, 2'h3};
    repeat (2) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    check("rate_code", 8'(rate_code), 8'h02);
    check("rwc_n", 8'(rwc_n), 8'h00);
    check("precomp", 8'(pc_units), 8'h06);
    check("fifo_en", 8'(fifo_en), 8'h00);
    bus_rd(3'h4, d);
    check("msr", d, 8'h80);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      bus_wr(3'h4, 8'(c));
      check("rate_code", 8'(rate_code), 8'(c));
      check("rwc_n", 8'(rwc_n), 8'(c == 0 || c == 3));
      check("precomp", 8'(pc_units), (c == 3) ? 8'h02 : 8'h06);
    end
    seq_u.set_mode(1'b0, 2'h2);
    for (int p = 0; p < 8; p++) begin
      bus_wr(3'h4, 8'(p * 4 + 2));
      check("precomp", 8'(pc_units), p == 0 ? 8'h06 : (p == 7 ? 8'h00 : 8'(p * 2)));
      bus_wr(3'h4, 8'(p * 4 + 1));
      check("tape_2m", 8'(tape_2m), 8'h01);
      check("precomp", 8'(pc_units), p == 0 ? 8'h01 : (p == 7 ? 8'h00 : 8'(p)));
    end
    bus_wr(3'h4, 8'h00);
    check("tape_2m", 8'(tape_2m), 8'h00);
    seq_u.set_mode(1'b0, 2'h1);
    bus_wr(3'h4, 8'h01);
    check("tape_2m", 8'(tape_2m), 8'h00);
    $display("test rate and precomp done");
    seq_u.rcr_write(2'h3);
    check("rate_code", 8'(rate_code), 8'h03);
    bus_wr(3'h4, 8'h01);
    check("rate_code", 8'(rate_code), 8'h01);
    seq_u.set_mode(1'b1, 2'h1);
    @(posedge i_clk) #1;
    check("rate_code", 8'(rate_code), 8'h03);
    bus_wr(3'h4, 8'h00);
    check("rate_code", 8'(rate_code), 8'h03);
    seq_u.set_mode(1'b0, 2'h1);
    $display("test rate source done");
    bus_wr(3'h4, 8'h42);
    check("power_down", 8'(power_down), 8'h01);
    bus_rd(3'h4, d);
    check("msr", d, 8'h00);
    bus_wr(3'h4, 8'h02);
    check("power_down", 8'(power_down), 8'h00);
    seq_u.configure(1'b1);
    check("fifo_en", 8'(fifo_en), 8'h01);
    bus_wr(3'h5, 8'ha5);
    check("cmd_valid", 8'(cmd_valid), 8'h01);
    check("cmd_byte", cmd_byte, 8'ha5);
    seq_u.end_cmd(tbl[0]);
    bus_wr(3'h4, 8'h80);
    check("soft_reset", 8'(soft_reset), 8'h01);
    check("fifo_en", 8'(fifo_en), 8'h00);
    @(posedge i_clk) #1;
    check("soft_reset", 8'(soft_reset), 8'h00);
    bus_rd(3'h4, d);
    check("msr", d, 8'h80);
    $display("test power, configure and reset done");
    for (int k = 0; k < 4; k++) begin
      seq_u.end_cmd(tbl[k]);
      bus_wr(3'h5, 8'h3c);
      check("cmd_valid", 8'(cmd_valid), 8'h00);
      for (int j = 1; j < 5; j++)
        if (k == 0) seq_u.push(8'(8'h11 * j));
      for (int j = 0; j < ((k == 0) ? 4 : 1); j++) begin
        bus_rd(3'h4, d);
        check("msr", d, 8'hc0);
        bus_rd(3'h5, d);
        exp_byte = (j == 0) ? status0(tbl[k]) : 8'(8'h11 * j);
        check("result", d, exp_byte);
      end
      bus_rd(3'h4, d);
      check("msr", d, 8'h80);
      bus_rd(3'h5, d);
      check("empty_port", d, 8'h00);
    end
    // read the status byte on the first edge it can be popped
    fork
      seq_u.end_cmd(tbl[1]);
      begin
        @(posedge i_clk);
        bus_rd(3'h5, d);
      end
    join
    check("result", d, status0(tbl[1]));
    bus_rd(3'h4, d);
    check("msr", d, 8'h80);
    seq_u.configure(1'b1);
    check("fifo_en", 8'(fifo_en), 8'h01);
    seq_u.configure(1'b0);
    check("fifo_en", 8'(fifo_en), 8'h00);
    $display("test result stack done");
    stop_test();
  end
endmodule
